// *** inc/led_pwm_consts.svh ***
`ifndef LED_PWM_CONSTS_SVH
`define LED_PWM_CONSTS_SVH

// Clock rates, in MHz
`define CORE_CLK_MHZ        20
`define OSC_MHZ             8
// Fractional step that turns the core clock into the 8 MHz oscillator tick
`define OSC_ACC_STEP        (5'(`OSC_MHZ))
`define OSC_ACC_MOD         (5'(`CORE_CLK_MHZ))
// Oscillator ticks per blink step at the fastest blink rate
`define BLINK_PRESCALE_TICKS 2048
`define BLINK_PRESCALE_LAST (11'(`BLINK_PRESCALE_TICKS - 1))

// Register pointers
`define PTR_MODE1           7'h00
`define PTR_MODE2           7'h01
`define PTR_LEDOUT0         7'h02
`define PTR_LEDOUT3         7'h05
`define PTR_GRPPWM          7'h08
`define PTR_GRPFREQ         7'h09
`define PTR_PWM0            7'h0A
`define PTR_PWM15           7'h19
`define PTR_IREF0           7'h22
`define PTR_IREF15          7'h31
`define PTR_SUBADR1         7'h3A
`define PTR_SUBADR3         7'h3C
`define PTR_ALLCALL         7'h3D
`define PTR_STAGGER         7'h3F
`define PTR_LAST            7'h41

// Field positions
`define MODE1_AI_LSB        5
`define MODE2_OCH_BIT       3
`define MODE2_BLINK_BIT     5

// Reset values
`define MODE1_RST           8'h09
`define MODE2_RST           8'h00
`define GRPPWM_RST          8'hFF
`define SUBADR_RST          8'hEC
`define ALLCALL_RST         8'hE0

// Bus addresses and commands
`define HW_ADDR_FIXED       3'h6
`define GENERAL_CALL        7'h00
`define SOFT_RESET_BYTE     8'h06

`endif

// *** inc/led_pwm_pkg.sv ***
package led_pwm_pkg;
   typedef enum logic [1:0] {
      CH_OFF = 2'b00,
      CH_ON  = 2'b01,
      CH_IND = 2'b10,
      CH_GRP = 2'b11
   } chan_state_t;

   typedef enum logic [2:0] {
      RX_IDLE  = 3'b000,
      RX_ADDR  = 3'b001,
      RX_CTRL  = 3'b010,
      RX_DATA  = 3'b011,
      RX_GCALL = 3'b100,
      RX_SKIP  = 3'b101
   } rx_state_t;
endpackage

// *** inc/reg_write_if.sv ***
`timescale 1ns/10ps
interface reg_write_if;
   logic            wr_pulse;
   logic [6:0]      wr_addr;
   logic [7:0]      wr_data;
   logic            stop_pulse;
   logic            soft_reset;
   logic [1:0]      ai_mode;
   logic [3:0]      addr_en;
   logic [2:0][7:0] sub_addr;
   logic [7:0]      allcall_addr;

   modport rx (output wr_pulse, wr_addr, wr_data, stop_pulse, soft_reset,
               input  ai_mode, addr_en, sub_addr, allcall_addr);
   modport regs (input  wr_pulse, wr_addr, wr_data, stop_pulse, soft_reset,
                 output ai_mode, addr_en, sub_addr, allcall_addr);
endinterface

// *** rtl/channel_pwm.sv ***
`timescale 1ns/10ps
module channel_pwm #(
   parameter logic [3:0] CH = 4'h0
) (
   // Clock and reset
   input  wire logic                     core_clk,
   input  wire logic                     rst,
   // Timebase and settings
   input  wire logic [7:0]               pwm_cnt,
   input  wire logic [7:0]               duty,
   input  wire logic [7:0]               stagger,
   input  wire led_pwm_pkg::chan_state_t state,
   input  wire logic                     grp_on,
   input  wire logic                     shutdown,
   // Sink drive
   output logic                          sink_on
);
   logic [11:0] shift;
   logic [7:0]  phase;
   logic        ind_on;
   logic        next_sink_on;

   // Phase shifted by channel index times stagger
   assign shift  = 12'(CH) * 12'(stagger);
   assign phase  = pwm_cnt - shift[7:0];
   assign ind_on = phase < duty;

   // Output state select
   always_comb begin
      unique case (state)
         led_pwm_pkg::CH_OFF: next_sink_on = 1'b0;
         led_pwm_pkg::CH_ON:  next_sink_on = 1'b1;
         led_pwm_pkg::CH_IND: next_sink_on = ind_on;
         led_pwm_pkg::CH_GRP: next_sink_on = ind_on & grp_on;
      endcase
      if (shutdown) begin
         next_sink_on = 1'b0;
      end
   end

   // Registered, off from reset
   always_ff @(posedge core_clk) begin
      if (rst) begin
         sink_on <= 1'b0;
      end else begin
         sink_on <= next_sink_on;
      end
   end
endmodule

// *** rtl/uf_bus_receiver.sv ***
`timescale 1ns/10ps
`include "led_pwm_consts.svh"
module uf_bus_receiver (
   // Clock and reset
   input  wire logic       core_clk,
   input  wire logic       rst,
   // Bus pins
   input  wire logic       scl_pin,
   input  wire logic       sda_pin,
   input  wire logic [3:0] hw_addr_pin,
   // Register write side
   reg_write_if.rx         wr
);
   logic [1:0] scl_sync, sda_sync;
   logic [3:0] hw_s1, hw_s2;
   logic       scl_d, sda_d, scl_f, sda_f, scl_fd, sda_fd;
   logic       next_scl_f, next_sda_f;
   logic       scl_rise, start_det, stop_det;
   led_pwm_pkg::rx_state_t state, next_state;
   logic [3:0] bit_cnt, next_bit_cnt;
   logic [7:0] shreg, next_shreg;
   logic [6:0] ptr, next_ptr;
   logic       pointer_autoinc_flag, next_aif;
   logic       next_wr_pulse, next_stop_pulse, next_soft_reset;
   logic [6:0] next_wr_addr;
   logic [7:0] next_wr_data;
   logic       addr_hit;

   // Two-stage synchronisers, then a one-sample stability filter
   always_comb begin
      next_scl_f = (scl_sync[1] == scl_d) ? scl_sync[1] : scl_f; // [RULE_19]
      next_sda_f = (sda_sync[1] == sda_d) ? sda_sync[1] : sda_f; // [RULE_19]
   end

   always_ff @(posedge core_clk) begin
      if (rst) begin
         scl_sync <= 2'h3;
         sda_sync <= 2'h3;
         hw_s1    <= 4'h0;
         hw_s2    <= 4'h0;
         scl_d    <= 1'b1;
         sda_d    <= 1'b1;
         scl_f    <= 1'b1;
         sda_f    <= 1'b1;
         scl_fd   <= 1'b1;
         sda_fd   <= 1'b1;
      end else begin
         scl_sync <= {scl_sync[0], scl_pin};
         sda_sync <= {sda_sync[0], sda_pin};
         hw_s1    <= hw_addr_pin;
         hw_s2    <= hw_s1;
         scl_d    <= scl_sync[1];
         sda_d    <= sda_sync[1];
         scl_f    <= next_scl_f;
         sda_f    <= next_sda_f;
         scl_fd   <= scl_f;
         sda_fd   <= sda_f;
      end
   end

   // Line events on filtered levels
   assign scl_rise  = scl_f & ~scl_fd;
   assign start_det = scl_f & scl_fd & sda_fd & ~sda_f;
   assign stop_det  = scl_f & scl_fd & ~sda_fd & sda_f;

   // Address match: pins, enabled sub calls, all call
   assign addr_hit = (shreg[7:1] == {`HW_ADDR_FIXED, hw_s2})                        // [RULE_09]
                   | (wr.addr_en[3] & (shreg[7:1] == wr.sub_addr[0][7:1]))         // [RULE_10]
                   | (wr.addr_en[2] & (shreg[7:1] == wr.sub_addr[1][7:1]))         // [RULE_10]
                   | (wr.addr_en[1] & (shreg[7:1] == wr.sub_addr[2][7:1]))         // [RULE_10]
                   | (wr.addr_en[0] & (shreg[7:1] == wr.allcall_addr[7:1]));       // [RULE_10]

   // Byte framing and pointer handling
   always_comb begin
      next_state      = state;
      next_bit_cnt    = bit_cnt;
      next_shreg      = shreg;
      next_ptr        = ptr;
      next_aif        = pointer_autoinc_flag;
      next_wr_pulse   = 1'b0;
      next_wr_addr    = wr.wr_addr;
      next_wr_data    = wr.wr_data;
      next_stop_pulse = 1'b0;
      next_soft_reset = 1'b0;
      if (stop_det) begin
         next_state      = led_pwm_pkg::RX_IDLE;
         next_stop_pulse = 1'b1;
      end else if (start_det) begin
         next_state   = led_pwm_pkg::RX_ADDR;
         next_bit_cnt = 4'h0;
      end else if (scl_rise && state != led_pwm_pkg::RX_IDLE) begin
         if (bit_cnt != 4'h8) begin
            next_shreg   = {shreg[6:0], sda_f};
            next_bit_cnt = bit_cnt + 4'h1;
         end else begin
            // Ninth bit is driven high by the master; no acknowledge here
            next_bit_cnt = 4'h0; // [RULE_08]
            unique case (state)
               led_pwm_pkg::RX_ADDR: begin
                  if (shreg[0]) begin
                     next_state = led_pwm_pkg::RX_SKIP; // [RULE_21] [RULE_06]
                  end else if (shreg[7:1] == `GENERAL_CALL) begin
                     next_state = led_pwm_pkg::RX_GCALL;
                  end else if (addr_hit) begin
                     next_state = led_pwm_pkg::RX_CTRL;
                  end else begin
                     next_state = led_pwm_pkg::RX_SKIP;
                  end
               end
               led_pwm_pkg::RX_CTRL: begin
                  next_aif   = shreg[7]; // [RULE_22]
                  next_ptr   = shreg[6:0]; // [RULE_22]
                  next_state = led_pwm_pkg::RX_DATA;
               end
               led_pwm_pkg::RX_DATA: begin
                  next_wr_pulse = 1'b1;
                  next_wr_addr  = ptr;
                  next_wr_data  = shreg;
                  if (pointer_autoinc_flag) begin
                     unique case (wr.ai_mode)
                        2'h0: next_ptr = (ptr >= `PTR_LAST) ? 7'h00 : ptr + 7'h01;
                        2'h1: next_ptr = (ptr >= `PTR_PWM15) ? `PTR_PWM0 : ptr + 7'h01;
                        2'h2: next_ptr = (ptr >= `PTR_IREF15) ? 7'h00 : ptr + 7'h01;
                        2'h3: next_ptr = (ptr >= `PTR_PWM15) ? `PTR_GRPPWM : ptr + 7'h01;
                     endcase
                  end
               end
               led_pwm_pkg::RX_GCALL: begin
                  next_soft_reset = (shreg == `SOFT_RESET_BYTE); // [RULE_12]
                  next_state      = led_pwm_pkg::RX_SKIP;
               end
               default: next_state = led_pwm_pkg::RX_SKIP;
            endcase
         end
      end
   end

   always_ff @(posedge core_clk) begin
      if (rst) begin
         state         <= led_pwm_pkg::RX_IDLE;
         bit_cnt       <= 4'h0;
         shreg         <= 8'h00;
         ptr           <= 7'h00;
         pointer_autoinc_flag           <= 1'b1;
         wr.wr_pulse   <= 1'b0;
         wr.wr_addr    <= 7'h00;
         wr.wr_data    <= 8'h00;
         wr.stop_pulse <= 1'b0;
         wr.soft_reset <= 1'b0;
      end else begin
         state         <= next_state;
         bit_cnt       <= next_bit_cnt;
         shreg         <= next_shreg;
         ptr           <= next_ptr;
         pointer_autoinc_flag           <= next_aif;
         wr.wr_pulse   <= next_wr_pulse;
         wr.wr_addr    <= next_wr_addr;
         wr.wr_data    <= next_wr_data;
         wr.stop_pulse <= next_stop_pulse;
         wr.soft_reset <= next_soft_reset;
      end
   end
endmodule

// *** rtl/led_pwm_write_only_bus_driver.sv ***
`timescale 1ns/10ps
`include "led_pwm_consts.svh"
// Operation
// [RULE_01] Each channel has an 8-bit PWM at 31.25 kHz, duty 0 to 255/256.
// [RULE_02] Group PWM dims at 122 Hz in 256 steps, full brightness after reset.
// [RULE_03] Blink mode: group period 15 Hz down to 16.8 s, 256-step duty.
// [RULE_04] Each channel is off, on, individual PWM, or individual and group PWM.
// [RULE_05] Channel brightness is linear in 256 steps and starts fully off.
// [RULE_06] Bus slave only receives writes; nothing is readable.
// [RULE_07] Output states change at each ninth bit or at STOP; STOP is default.
// [RULE_08] Master drives the ninth bit high itself; slave never acknowledges.
// [RULE_09] Four address pins form the regular slave address, sixteen devices per bus.
// [RULE_10] Group call and three sub call addresses, each enabled separately.
// [RULE_11] First sub call address is enabled after reset with the 16-channel value.
// [RULE_12] Soft reset call over the bus equals power-on reset.
// [RULE_13] Programmable stagger delays channel turn-on to limit surge current.
// [RULE_14] An 8-bit linear setting scales the channel sink current.
// [RULE_15] Logic and PWM timing run from an 8 MHz oscillator rate.
// [RULE_16] Low level on the reset pin resets the device.
// [RULE_17] Overtemperature shuts all channel outputs off.
// [RULE_18] Channel outputs stay off and glitch-free from power-up.
// [RULE_19] Serial clock and data pass a noise filter before protocol logic.
// [RULE_20] Bus accepts transfers up to 5 MHz bit rate.
// [RULE_21] Last address bit must be zero; read requests are ignored.
// [RULE_22] First data byte is the pointer: seven bits address, top bit auto-increment.
// [RULE_23] Combined state drives only while individual and group PWM are both active.
module led_pwm_write_only_bus_driver (
   // Clock and reset
   input  wire logic              core_clk,
   input  wire logic              rst_n,
   // Serial bus
   input  wire logic              serial_clock_line,
   input  wire logic              serial_data_line,
   // Hardware address straps
   input  wire logic              hw_addr_pin_0,
   input  wire logic              hw_addr_pin_1,
   input  wire logic              hw_addr_pin_2,
   input  wire logic              hw_addr_pin_3,
   // Thermal sensor
   input  wire logic              overtemp_detect,
   // Channel drive
   output logic [15:0]            channel_sink_output,
   output logic [15:0][7:0]       sink_current_setting
);
   reg_write_if wr ();

   logic             rst;
   logic [1:0]       ot_sync;
   logic             shutdown;
   logic [7:0]       mode1, next_mode1;
   logic [7:0]       mode2, next_mode2;
   logic [31:0]      ledout_sh, next_ledout_sh;
   logic [31:0]      ledout_act, next_ledout_act;
   logic [7:0]       grppwm, next_grppwm;
   logic [7:0]       grpfreq, next_grpfreq;
   logic [15:0][7:0] pwm_duty, next_pwm_duty;
   logic [15:0][7:0] next_iref;
   logic [2:0][7:0]  sub_addr, next_sub_addr;
   logic [7:0]       allcall_addr, next_allcall_addr;
   logic [7:0]       stagger, next_stagger;
   logic [4:0]       osc_acc, next_osc_acc;
   logic             osc_tick;
   logic [7:0]       pwm_cnt, next_pwm_cnt;
   logic [10:0]      blink_pre, next_blink_pre;
   logic [7:0]       freq_div, next_freq_div;
   logic [7:0]       grp_cnt, next_grp_cnt;
   logic             grp_on, next_grp_on;
   logic             grp_step;

   // Pin reset or bus soft reset
   assign rst = ~rst_n | wr.soft_reset; // [RULE_16] [RULE_12]

   // Overtemperature input synchroniser
   always_ff @(posedge core_clk) begin
      if (rst) begin
         ot_sync <= 2'h0;
      end else begin
         ot_sync <= {ot_sync[0], overtemp_detect};
      end
   end
   assign shutdown = ot_sync[1]; // [RULE_17]

   // Bus receiver
   uf_bus_receiver u_rx (
      .core_clk    (core_clk),
      .rst         (rst),
      .scl_pin     (serial_clock_line), // [RULE_20]
      .sda_pin     (serial_data_line),
      .hw_addr_pin ({hw_addr_pin_3, hw_addr_pin_2, hw_addr_pin_1, hw_addr_pin_0}),
      .wr          (wr.rx)
   );

   // Configuration fed back to the receiver
   assign wr.ai_mode      = mode1[`MODE1_AI_LSB +: 2];
   assign wr.addr_en      = mode1[3:0];
   assign wr.sub_addr     = sub_addr;
   assign wr.allcall_addr = allcall_addr;

   // Register writes from the bus
   always_comb begin
      logic [3:0] pidx;
      logic [3:0] iidx;
      logic [1:0] lidx;
      logic [1:0] sidx;
      pidx              = 4'(wr.wr_addr - `PTR_PWM0);
      iidx              = 4'(wr.wr_addr - `PTR_IREF0);
      lidx              = 2'(wr.wr_addr - `PTR_LEDOUT0);
      sidx              = 2'(wr.wr_addr - `PTR_SUBADR1);
      next_mode1        = mode1;
      next_mode2        = mode2;
      next_ledout_sh    = ledout_sh;
      next_grppwm       = grppwm;
      next_grpfreq      = grpfreq;
      next_pwm_duty     = pwm_duty;
      next_iref         = sink_current_setting;
      next_sub_addr     = sub_addr;
      next_allcall_addr = allcall_addr;
      next_stagger      = stagger;
      if (wr.wr_pulse) begin
         if (wr.wr_addr == `PTR_MODE1) begin
            next_mode1 = wr.wr_data;
         end
         if (wr.wr_addr == `PTR_MODE2) begin
            next_mode2 = wr.wr_data;
         end
         if (wr.wr_addr >= `PTR_LEDOUT0 && wr.wr_addr <= `PTR_LEDOUT3) begin
            next_ledout_sh[8*lidx +: 8] = wr.wr_data;
         end
         if (wr.wr_addr == `PTR_GRPPWM) begin
            next_grppwm = wr.wr_data;
         end
         if (wr.wr_addr == `PTR_GRPFREQ) begin
            next_grpfreq = wr.wr_data;
         end
         if (wr.wr_addr >= `PTR_PWM0 && wr.wr_addr <= `PTR_PWM15) begin
            next_pwm_duty[pidx] = wr.wr_data; // [RULE_05]
         end
         if (wr.wr_addr >= `PTR_IREF0 && wr.wr_addr <= `PTR_IREF15) begin
            next_iref[iidx] = wr.wr_data; // [RULE_14]
         end
         if (wr.wr_addr >= `PTR_SUBADR1 && wr.wr_addr <= `PTR_SUBADR3) begin
            next_sub_addr[sidx] = wr.wr_data; // [RULE_10]
         end
         if (wr.wr_addr == `PTR_ALLCALL) begin
            next_allcall_addr = wr.wr_data; // [RULE_10]
         end
         if (wr.wr_addr == `PTR_STAGGER) begin
            next_stagger = wr.wr_data; // [RULE_13]
         end
      end
   end

   // Output state commit: per byte or at STOP
   always_comb begin
      next_ledout_act = ledout_act;
      if (mode2[`MODE2_OCH_BIT]) begin
         if (wr.wr_pulse) begin
            next_ledout_act = next_ledout_sh; // [RULE_07]
         end
      end else if (wr.stop_pulse) begin
         next_ledout_act = ledout_sh; // [RULE_07]
      end
   end

   // Configuration registers
   always_ff @(posedge core_clk) begin
      if (rst) begin
         mode1                <= `MODE1_RST; // [RULE_11]
         mode2                <= `MODE2_RST;
         ledout_sh            <= 32'h0000_0000;
         ledout_act           <= 32'h0000_0000; // [RULE_18]
         grppwm               <= `GRPPWM_RST; // [RULE_02]
         grpfreq              <= 8'h00;
         pwm_duty             <= '0; // [RULE_05]
         sink_current_setting <= '0;
         sub_addr             <= {3{`SUBADR_RST}}; // [RULE_11]
         allcall_addr         <= `ALLCALL_RST;
         stagger              <= 8'h00;
      end else begin
         mode1                <= next_mode1;
         mode2                <= next_mode2;
         ledout_sh            <= next_ledout_sh;
         ledout_act           <= next_ledout_act;
         grppwm               <= next_grppwm;
         grpfreq              <= next_grpfreq;
         pwm_duty             <= next_pwm_duty;
         sink_current_setting <= next_iref;
         sub_addr             <= next_sub_addr;
         allcall_addr         <= next_allcall_addr;
         stagger              <= next_stagger;
      end
   end

   // Oscillator tick, group step and group comparator
   always_comb begin
      logic [5:0] acc_sum;
      acc_sum        = {1'b0, osc_acc} + {1'b0, `OSC_ACC_STEP};
      osc_tick       = acc_sum >= {1'b0, `OSC_ACC_MOD}; // [RULE_15]
      next_osc_acc   = osc_tick ? 5'(acc_sum - {1'b0, `OSC_ACC_MOD}) : acc_sum[4:0];
      next_pwm_cnt   = osc_tick ? pwm_cnt + 8'h01 : pwm_cnt; // [RULE_01]
      next_blink_pre = osc_tick ? blink_pre + 11'h001 : blink_pre;
      next_freq_div  = freq_div;
      if (mode2[`MODE2_BLINK_BIT]) begin
         grp_step = 1'b0;
         if (osc_tick && blink_pre == `BLINK_PRESCALE_LAST) begin
            if (freq_div >= grpfreq) begin
               next_freq_div = 8'h00;
               grp_step      = 1'b1; // [RULE_03]
            end else begin
               next_freq_div = freq_div + 8'h01;
            end
         end
      end else begin
         grp_step = osc_tick && pwm_cnt == 8'hFF; // [RULE_02]
      end
      next_grp_cnt = grp_step ? grp_cnt + 8'h01 : grp_cnt;
      next_grp_on  = grp_cnt < grppwm; // [RULE_02] [RULE_03]
   end

   always_ff @(posedge core_clk) begin
      if (rst) begin
         osc_acc   <= 5'h00;
         pwm_cnt   <= 8'h00;
         blink_pre <= 11'h000;
         freq_div  <= 8'h00;
         grp_cnt   <= 8'h00;
         grp_on    <= 1'b0;
      end else begin
         osc_acc   <= next_osc_acc;
         pwm_cnt   <= next_pwm_cnt;
         blink_pre <= next_blink_pre;
         freq_div  <= next_freq_div;
         grp_cnt   <= next_grp_cnt;
         grp_on    <= next_grp_on;
      end
   end

   // Sixteen channel output stages
   for (genvar g = 0; g < 16; g++) begin : gen_ch
      channel_pwm #(
         .CH (4'(g))
      ) u_ch (
         .core_clk (core_clk),
         .rst      (rst),
         .pwm_cnt  (pwm_cnt), // [RULE_01]
         .duty     (pwm_duty[g]),
         .stagger  (stagger), // [RULE_13]
         .state    (led_pwm_pkg::chan_state_t'(ledout_act[2*g +: 2])), // [RULE_04] [RULE_23]
         .grp_on   (grp_on),
         .shutdown (shutdown), // [RULE_17]
         .sink_on  (channel_sink_output[g])
      );
   end
endmodule

// *** verif/led_pwm_checker_assertions.sv ***
`timescale 1ns/10ps
module led_pwm_checker (
   // Clock and reset
   input wire logic             core_clk,
   input wire logic             rst_n,
   // Pins watched
   input wire logic             serial_clock_line,
   input wire logic             serial_data_line,
   input wire logic             overtemp_detect,
   input wire logic [15:0]      channel_sink_output,
   input wire logic [15:0][7:0] sink_current_setting
);
   logic       scl_q;
   logic [4:0] since_rise;
   logic       seen_frame;
   // Cycles since a bus clock rise, and any frame since reset
   always_ff @(posedge core_clk) begin
      scl_q <= serial_clock_line;
      if (!rst_n) since_rise <= 5'h1F;
      else if (serial_clock_line && !scl_q) since_rise <= 5'h00;
      else if (since_rise != 5'h1F) since_rise <= since_rise + 5'h01;
      seen_frame <= rst_n && (seen_frame || !serial_clock_line);
   end
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!rst_n);
   // Bus idle and sustained overheat
   sequence bus_idle;
      (serial_clock_line && serial_data_line) [*8];
   endsequence
   sequence heat;
      overtemp_detect [*6];
   endsequence
   a_reset_out_off: assert property (disable iff (1'b0) !rst_n |=> channel_sink_output == 16'h0000)
      else $error("outputs not cleared by reset");
   a_reset_cur_zero: assert property (disable iff (1'b0) !rst_n |=> sink_current_setting == 128'h0)
      else $error("current settings not cleared by reset");
   a_idle_cur_stable: assert property (bus_idle |-> $stable(sink_current_setting))
      else $error("current setting moved on an idle bus");
   a_cur_after_clock: assert property ($changed(sink_current_setting) |-> since_rise < 5'h10)
      else $error("current setting moved far from a bus clock rise");
   a_powerup_quiet: assert property (!seen_frame |-> channel_sink_output == 16'h0000)
      else $error("output pulse before any configuration");
   a_heat_off: assert property (heat |-> channel_sink_output == 16'h0000)
      else $error("outputs driven during overheat");
   a_heat_fast: assert property ($rose(overtemp_detect) |-> ##[1:6] channel_sink_output == 16'h0000)
      else $error("shutdown too slow");
   a_heat_hold: assert property (heat ##1 overtemp_detect |-> $stable(channel_sink_output))
      else $error("outputs moved during shutdown");
endmodule
bind led_pwm_write_only_bus_driver led_pwm_checker i_led_pwm_checker (
   .core_clk(core_clk), .rst_n(rst_n), .serial_clock_line(serial_clock_line),
   .serial_data_line(serial_data_line), .overtemp_detect(overtemp_detect),
   .channel_sink_output(channel_sink_output), .sink_current_setting(sink_current_setting));

// *** verif/uf_bus_master.sv ***
`timescale 1ns/10ps
module uf_bus_master (
   // Clock
   input  wire logic core_clk,
   // Push-pull bus lines, idle high
   output logic      scl = 1'b1,
   output logic      sda = 1'b1
);
   // Whole core cycles; four make half of a 400 ns bit
   task automatic hold_for(input int n);
      repeat (n) @(posedge core_clk);
   endtask
   // Clock stands high between frames
   task automatic start();
      sda <= 1'b0;
      hold_for(4);
      scl <= 1'b0;
      hold_for(2);
   endtask
   task automatic put_bit(input logic b);
      sda <= b;
      hold_for(2);
      scl <= 1'b1;
      hold_for(4);
      scl <= 1'b0;
      hold_for(2);
   endtask
   // Write bytes only, MSB first, ninth bit driven high
   task automatic put_byte(input logic [7:0] b);
      for (int i = 7; i >= 0; i--)
         put_bit(b[i]);
      put_bit(1'b1);
   endtask
   task automatic stop();
      sda <= 1'b0;
      hold_for(2);
      scl <= 1'b1;
      hold_for(4);
      sda <= 1'b1;
      hold_for(4);
   endtask
endmodule

// *** verif/test_led_pwm_write_only_bus_driver.sv ***
`timescale 1ns/10ps
`include "led_pwm_consts.svh"
module test_led_pwm_write_only_bus_driver;
   localparam logic [3:0] PINS  = 4'hD;
   localparam logic [7:0] DEV_W = {`HW_ADDR_FIXED, PINS, 1'b0};
   logic             core_clk  = 1'b0;
   logic             rst_n     = 1'b0;
   logic             overheat  = 1'b0;
   logic [3:0]       pins      = PINS;
   logic             scl;
   logic             sda;
   logic [15:0]      sink_out;
   logic [15:0][7:0] cur;
   int               failures  = 0;
   int               tests_run = 0;
   // 20 MHz core clock
   always #25 core_clk = ~core_clk;
   led_pwm_write_only_bus_driver i_led_pwm_write_only_bus_driver (
      .core_clk(core_clk), .rst_n(rst_n), .serial_clock_line(scl), .serial_data_line(sda),
      .hw_addr_pin_0(pins[0]), .hw_addr_pin_1(pins[1]), .hw_addr_pin_2(pins[2]), .hw_addr_pin_3(pins[3]),
      .overtemp_detect(overheat), .channel_sink_output(sink_out), .sink_current_setting(cur));
   uf_bus_master i_uf_bus_master (.core_clk(core_clk), .scl(scl), .sda(sda));
   task automatic check(input string what, input logic [127:0] seen, input logic [127:0] want);
      tests_run++;
      if (seen !== want) begin
         failures++;
         $display("unexpected %s expected %0h seen %0h", what, want, seen);
      end
   endtask
   task automatic end_of_test();
      $display("comparisons %0d mismatches %0d", tests_run, failures);
      if (failures == 0 && tests_run > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask
   // Bytes of a frame left open before its stop
   task automatic send(input logic [7:0] q [$]);
      i_uf_bus_master.start();
      foreach (q[i])
         i_uf_bus_master.put_byte(q[i]);
      i_uf_bus_master.hold_for(20);
   endtask
   task automatic wr(input logic [7:0] q [$]);
      send(q);
      i_uf_bus_master.stop();
      i_uf_bus_master.hold_for(20);
   endtask
   // High cycles of channel 0 over one 256-tick period
   task automatic duty_is(input logic [9:0] want);
      logic [9:0] n;
      n = 10'h000;
      repeat (640) begin
         @(posedge core_clk);
         n += 10'(sink_out[0]);
      end
      check("ch0 high cycles", n, want);
   endtask
   task automatic t_address();
      wr('{DEV_W, 8'hA2, 8'h11, 8'h22});
      check("currents 0-1", cur[1:0], 16'h2211);
      wr('{{`HW_ADDR_FIXED, ~PINS, 1'b0}, 8'hA2, 8'h33});
      wr('{DEV_W | 8'h01, 8'hA2, 8'h33});
      check("currents kept", cur[1:0], 16'h2211);
      wr('{`SUBADR_RST, 8'hA4, 8'h44});
      wr('{DEV_W, 8'h00, 8'h01});
      wr('{`SUBADR_RST, 8'hA4, 8'h77});
      wr('{DEV_W, 8'h25, 8'h55, 8'h66});
      check("currents 2-4", cur[4:2], 24'h00_6644);
      $display("test address done");
   endtask
   task automatic t_state();
      send('{DEV_W, {1'b1, `PTR_LEDOUT0}, 8'h01});
      check("out before stop", sink_out, 16'h0000);
      i_uf_bus_master.stop();
      i_uf_bus_master.hold_for(20);
      check("out on", sink_out, 16'h0001);
      overheat <= 1'b1;
      i_uf_bus_master.hold_for(10);
      check("out hot", sink_out, 16'h0000);
      overheat <= 1'b0;
      i_uf_bus_master.hold_for(10);
      check("out cooled", sink_out, 16'h0001);
      wr('{DEV_W, {1'b0, `PTR_MODE2}, 8'h08});
      send('{DEV_W, {1'b0, `PTR_LEDOUT0}, 8'h00});
      check("out per byte", sink_out, 16'h0000);
      i_uf_bus_master.stop();
      $display("test state done");
   endtask
   task automatic t_pwm();
      wr('{DEV_W, {1'b0, `PTR_PWM0}, 8'h80});
      wr('{DEV_W, {1'b0, `PTR_LEDOUT0}, 8'h02});
      duty_is(10'h140);
      wr('{DEV_W, {1'b0, `PTR_GRPPWM}, 8'h00});
      wr('{DEV_W, {1'b0, `PTR_LEDOUT0}, 8'h03});
      duty_is(10'h000);
      $display("test pwm done");
   endtask
   task automatic t_soft_reset();
      wr('{DEV_W, {1'b0, `PTR_LEDOUT0}, 8'h01});
      wr('{{`GENERAL_CALL, 1'b0}, `SOFT_RESET_BYTE});
      check("out after soft reset", sink_out, 16'h0000);
      check("currents after soft reset", cur, 128'h0);
      $display("test soft reset done");
   endtask
   // Reset, then each scenario in turn
   initial begin
      repeat (5) @(posedge core_clk);
      rst_n <= 1'b1;
      repeat (4) @(posedge core_clk);
      check("out after reset", sink_out, 16'h0000);
      check("currents after reset", cur, 128'h0);
      t_address();
      t_state();
      t_pwm();
      t_soft_reset();
      end_of_test();
   end
   // Watchdog far beyond the 5,700 cycles expected
   initial begin
      #2_000_000;
      failures++;
      end_of_test();
   end
endmodule
